// File: shared/exec_pkg.sv
// Purpose: shared constants and types for the bit and arithmetic executor
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   opcodes follow the usual mid-range encoding

package exec_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int BIT_W   = 3;
    localparam int INSTR_W = 14;

    // ----------------------------------------------------------------
    // instruction fields
    // ----------------------------------------------------------------
    localparam int ADDR_LSB = 0;
    localparam int DEST_POS = 7;
    localparam int BIT_LSB  = 7;
    localparam int LIT_LSB  = 0;
    localparam int NIB_POS  = 4;

    // ----------------------------------------------------------------
    // opcodes: byte ops top 6 bits, bit ops top 4, literal ops top 5
    // ----------------------------------------------------------------
    localparam logic [5:0] OPC_ADD_REG = 6'h07;
    localparam logic [5:0] OPC_AND_REG = 6'h05;
    localparam logic [3:0] OPC_BIT_CLR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_SKIP_Z  = 4'h6;
    localparam logic [3:0] OPC_SKIP_O  = 4'h7;
    localparam logic [4:0] OPC_ADD_IMM = 5'h1f;
    localparam logic [4:0] OPC_AND_IMM = 5'h1c;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;

    typedef enum logic [8:0] {
        OP_NONE     = 9'h001,
        OP_ADD_IMM  = 9'h002,
        OP_ADD_REG  = 9'h004,
        OP_AND_IMM  = 9'h008,
        OP_AND_REG  = 9'h010,
        OP_BIT_CLR  = 9'h020,
        OP_BIT_SET  = 9'h040,
        OP_SKIP_ONE = 9'h080,
        OP_SKIP_ZER = 9'h100
    } op_kind_t;

    typedef struct packed {
        logic carry;
        logic digit_carry;
        logic zero;
    } flags_t;

    typedef struct packed {
        op_kind_t              kind;
        logic [ADDR_W-1:0]     addr;
        logic                  dest_reg;
        logic [BIT_W-1:0]      bit_sel;
        logic [DATA_W-1:0]     literal;
    } decoded_t;

    typedef struct packed {
        logic                  we;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     data;
    } file_write_t;

endpackage : exec_pkg

// File: hw/instr_decode.sv
// Purpose: splits an instruction word into operation kind and fields
// Assumes: words outside this subset decode to OP_NONE
// Notes:   purely combinational

module instr_decode (
    // instruction in
    input  wire logic [exec_pkg::INSTR_W-1:0] instr,
    // decoded fields out
    output exec_pkg::decoded_t                dec
);

    // opcode fields sit at the top of the word, widths taken from the codes
    localparam int BYTE_OP_W = $bits(exec_pkg::OPC_ADD_REG);
    localparam int LIT_OP_W  = $bits(exec_pkg::OPC_ADD_IMM);
    localparam int BIT_OP_W  = $bits(exec_pkg::OPC_BIT_CLR);
    localparam int TOP       = exec_pkg::INSTR_W - 1;

    always_comb begin
        dec          = '0;
        dec.kind     = exec_pkg::OP_NONE;
        dec.addr     = instr[exec_pkg::ADDR_LSB +: exec_pkg::ADDR_W];
        dec.dest_reg = instr[exec_pkg::DEST_POS];
        dec.bit_sel  = instr[exec_pkg::BIT_LSB +: exec_pkg::BIT_W];
        dec.literal  = instr[exec_pkg::LIT_LSB +: exec_pkg::DATA_W];
        if (instr[TOP -: BYTE_OP_W] == exec_pkg::OPC_ADD_REG) begin
            dec.kind = exec_pkg::OP_ADD_REG;
        end else if (instr[TOP -: BYTE_OP_W] == exec_pkg::OPC_AND_REG) begin
            dec.kind = exec_pkg::OP_AND_REG;
        end else if (instr[TOP -: LIT_OP_W] == exec_pkg::OPC_ADD_IMM) begin
            dec.kind = exec_pkg::OP_ADD_IMM;
        end else if (instr[TOP -: LIT_OP_W] == exec_pkg::OPC_AND_IMM) begin
            dec.kind = exec_pkg::OP_AND_IMM;
        end else begin
            case (instr[TOP -: BIT_OP_W])
                exec_pkg::OPC_BIT_CLR: dec.kind = exec_pkg::OP_BIT_CLR;
                exec_pkg::OPC_BIT_SET: dec.kind = exec_pkg::OP_BIT_SET;
                exec_pkg::OPC_SKIP_Z:  dec.kind = exec_pkg::OP_SKIP_ZER;
                exec_pkg::OPC_SKIP_O:  dec.kind = exec_pkg::OP_SKIP_ONE;
                default:               dec.kind = exec_pkg::OP_NONE;
            endcase
        end
    end

endmodule : instr_decode

// File: hw/add_and_bit_ops_executor.sv
// Purpose: executes add, and, bit set/clear and bit-test-skip operations
// Assumes: one instruction presented per clk_sys edge with instr_valid
// Notes:   file register read is combinational through rd_addr/rd_data
//
// Operation
// - add-immediate adds an 8-bit literal to the accumulator into it.
// - add-register adds the accumulator to the 7-bit addressed file reg.
// - for register ops dest 0 writes accumulator, dest 1 the file reg.
// - and-immediate ands the accumulator with a literal into it.
// - and-register ands accumulator with file reg to the chosen dest.
// - bit-clear zeroes one selected bit of a file reg, no flags touched.
// - bit-set forces one selected bit of a file reg to one, no flags.
// - skip-if-one discards the next instruction when the bit is one.
// - skip-if-zero discards the next instruction when the bit is zero.

module add_and_bit_ops_executor (
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    // instruction stream
    input  wire logic                         instr_valid,
    input  wire logic [exec_pkg::INSTR_W-1:0] instr,
    // file register read port
    output logic      [exec_pkg::ADDR_W-1:0]  rd_addr,
    input  wire logic [exec_pkg::DATA_W-1:0]  rd_data,
    // file register write port
    output exec_pkg::file_write_t             file_wr,
    // core state
    output logic      [exec_pkg::DATA_W-1:0]  acc,
    output exec_pkg::flags_t                  flags,
    output logic                              skip_active,
    output logic                              instr_done
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [exec_pkg::DATA_W-1:0] acc;
        exec_pkg::flags_t            flags;
        logic                        skip;
        exec_pkg::file_write_t       wr;
        logic                        done;
    } state_t;

    state_t             state_reg;
    state_t             state_next;
    exec_pkg::decoded_t dec;

    // cast width for the per-bit select compare
    localparam int SEL_W = exec_pkg::BIT_W;

    logic [exec_pkg::DATA_W:0]   sum;
    logic [exec_pkg::DATA_W-1:0] sum_lo;
    logic [exec_pkg::NIB_POS:0]  low_sum;
    logic [exec_pkg::DATA_W-1:0] and_val;
    logic [exec_pkg::DATA_W-1:0] bit_mask;
    logic                        tested_bit;
    exec_pkg::flags_t            add_flags;
    logic                        and_zero;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    instr_decode u_decode (
        .instr (instr),
        .dec   (dec)
    );

    // address comes straight from the word so the read settles in the
    // same cycle the op is taken
    assign rd_addr = dec.addr;

    // ----------------------------------------------------------------
    // bit select, one mask bit per data bit
    // ----------------------------------------------------------------
    for (genvar b = 0; b < exec_pkg::DATA_W; b++) begin : g_mask
        assign bit_mask[b] = (dec.bit_sel == SEL_W'(b));
    end

    // ----------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------
    always_comb begin
        logic [exec_pkg::DATA_W-1:0] opnd;
        opnd = '0;
        case (dec.kind)
            exec_pkg::OP_ADD_IMM,
            exec_pkg::OP_AND_IMM: begin
                opnd = dec.literal;
            end
            default: begin
                opnd = rd_data;
            end
        endcase
        sum = {1'b0, state_reg.acc} + {1'b0, opnd};
        low_sum = {1'b0, state_reg.acc[exec_pkg::NIB_POS-1:0]}
                + {1'b0, opnd[exec_pkg::NIB_POS-1:0]};
        and_val = state_reg.acc & opnd;
        sum_lo = sum[exec_pkg::DATA_W-1:0];
        // adds report all three flags, ands only ever report zero
        add_flags.carry       = sum[exec_pkg::DATA_W];
        add_flags.digit_carry = low_sum[exec_pkg::NIB_POS];
        add_flags.zero        = (sum_lo == '0);
        and_zero = (and_val == '0);
        tested_bit = |(rd_data & bit_mask);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        state_next.wr = '0;
        state_next.done = 1'b0;
        // a skipped word is executed as a no-op, so the test spans two cycles
        if (instr_valid && state_reg.skip) begin
            state_next.skip = 1'b0;
            state_next.done = 1'b1;
        end else if (instr_valid) begin
            state_next.done = 1'b1;
            case (dec.kind)
                exec_pkg::OP_ADD_IMM: begin
                    state_next.acc   = sum_lo;
                    state_next.flags = add_flags;
                end
                exec_pkg::OP_ADD_REG: begin
                    state_next.flags = add_flags;
                    if (dec.dest_reg) begin
                        state_next.wr.we   = 1'b1;
                        state_next.wr.addr = dec.addr;
                        state_next.wr.data = sum_lo;
                    end else begin
                        state_next.acc = sum_lo;
                    end
                end
                exec_pkg::OP_AND_IMM: begin
                    state_next.acc        = and_val;
                    state_next.flags.zero = and_zero;
                end
                exec_pkg::OP_AND_REG: begin
                    // carry and digit carry keep their old values here
                    state_next.flags.zero = and_zero;
                    if (dec.dest_reg) begin
                        state_next.wr.we   = 1'b1;
                        state_next.wr.addr = dec.addr;
                        state_next.wr.data = and_val;
                    end else begin
                        state_next.acc = and_val;
                    end
                end
                exec_pkg::OP_BIT_CLR: begin
                    state_next.wr.we   = 1'b1;
                    state_next.wr.addr = dec.addr;
                    state_next.wr.data = rd_data & ~bit_mask;
                end
                exec_pkg::OP_BIT_SET: begin
                    state_next.wr.we   = 1'b1;
                    state_next.wr.addr = dec.addr;
                    state_next.wr.data = rd_data | bit_mask;
                end
                exec_pkg::OP_SKIP_ONE: begin
                    state_next.skip = tested_bit;
                end
                exec_pkg::OP_SKIP_ZER: begin
                    state_next.skip = ~tested_bit;
                end
                default: begin
                    state_next.done = 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg.acc   <= exec_pkg::ACC_RST;
            state_reg.flags <= '0;
            state_reg.skip  <= 1'b0;
            state_reg.wr    <= '0;
            state_reg.done  <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // write is registered on the edge that takes the op and commits on the next clk_sys edge, whether or not that edge takes an op
    assign file_wr     = state_reg.wr;
    assign acc         = state_reg.acc;
    assign flags       = state_reg.flags;
    assign skip_active = state_reg.skip;
    assign instr_done  = state_reg.done;

endmodule : add_and_bit_ops_executor

// File: verification/exec_monitor.sv
// Purpose: port-level property checks for the executor
// Assumes: rd_data settles in the same cycle as rd_addr
// Notes:   a discarded word must clear skip_active, write nothing and leave acc and flags untouched
module exec_monitor (
    // clock and reset
    input wire logic                         clk_sys,
    input wire logic                         rst,
    // observed ports
    input wire logic                         instr_valid,
    input wire logic [exec_pkg::INSTR_W-1:0] instr,
    input wire logic [exec_pkg::ADDR_W-1:0]  rd_addr,
    input wire logic [exec_pkg::DATA_W-1:0]  rd_data,
    input wire exec_pkg::file_write_t        file_wr,
    input wire logic [exec_pkg::DATA_W-1:0]  acc,
    input wire exec_pkg::flags_t             flags,
    input wire logic                         skip_active,
    input wire logic                         instr_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic       go;
    logic [3:0] op4;
    logic [4:0] op5;
    logic [5:0] op6;
    assign go  = instr_valid && !skip_active;
    assign op4 = instr[13:10];
    assign op5 = instr[13:9];
    assign op6 = instr[13:8];

    chk_done_pulse: assert property (instr_valid |=> instr_done)
        else $error("done pulse missing");
    chk_add_imm: assert property (
        go && op5 == exec_pkg::OPC_ADD_IMM
        |=> acc == $past(acc) + $past(instr[7:0]))
        else $error("add immediate wrong");
    chk_and_imm: assert property (
        go && op5 == exec_pkg::OPC_AND_IMM
        |=> acc == ($past(acc) & $past(instr[7:0]))
        && $stable(flags.carry) && $stable(flags.digit_carry))
        else $error("and immediate wrong");
    chk_add_wb: assert property (
        go && op6 == exec_pkg::OPC_ADD_REG && instr[7]
        |=> file_wr.we && $stable(acc)
        && file_wr.data == $past(acc) + $past(rd_data))
        else $error("add to file wrong");
    chk_and_acc: assert property (
        go && op6 == exec_pkg::OPC_AND_REG && !instr[7]
        |=> !file_wr.we && acc == ($past(acc) & $past(rd_data)))
        else $error("and to acc wrong");
    chk_bit_clr: assert property (
        go && op4 == exec_pkg::OPC_BIT_CLR
        |=> file_wr.we && file_wr.addr == $past(rd_addr) && $stable(flags)
        && file_wr.data == ($past(rd_data) & ~(8'h01 << $past(instr[9:7]))))
        else $error("bit clear wrong");
    chk_bit_set: assert property (
        go && op4 == exec_pkg::OPC_BIT_SET
        |=> file_wr.we && file_wr.addr == $past(rd_addr) && $stable(flags)
        && file_wr.data == ($past(rd_data) | (8'h01 << $past(instr[9:7]))))
        else $error("bit set wrong");
    chk_skip_one: assert property (
        go && op4 == exec_pkg::OPC_SKIP_O
        |=> skip_active == $past(rd_data[instr[9:7]]))
        else $error("skip if one wrong");
    chk_skip_zero: assert property (
        go && op4 == exec_pkg::OPC_SKIP_Z
        |=> skip_active == !$past(rd_data[instr[9:7]]))
        else $error("skip if zero wrong");
    chk_word_discard: assert property (
        instr_valid && skip_active
        |=> !skip_active && !file_wr.we && $stable(acc) && $stable(flags))
        else $error("discarded word acted");
endmodule : exec_monitor

bind add_and_bit_ops_executor exec_monitor u_mon (.clk_sys(clk_sys),
    .rst(rst), .instr_valid(instr_valid), .instr(instr), .rd_addr(rd_addr),
    .rd_data(rd_data), .file_wr(file_wr), .acc(acc), .flags(flags),
    .skip_active(skip_active), .instr_done(instr_done));

// File: verification/add_and_bit_ops_executor_test.sv
// Purpose: directed bench for the executor
// Assumes: bench file model forwards a pending write to rd_data
// Notes:   expected acc is tracked here, never read back from the design
module add_and_bit_ops_executor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  clk_sys = 1'b0;
    logic                  rst = 1'b1;
    logic                  instr_valid = 1'b0;
    logic [13:0]           instr = 14'h0000;
    logic [6:0]            rd_addr;
    logic [7:0]            rd_data;
    logic [7:0]            fm [128];
    logic [7:0]            ea;
    exec_pkg::file_write_t file_wr;
    logic [7:0]            acc;
    exec_pkg::flags_t      flags;
    logic                  skip_active;
    logic                  instr_done;
    int                    n_fail = 0;
    int                    samples_checked = 0;

    always #25 clk_sys = ~clk_sys;
    // forwarding: a write still in flight is what the next word must see
    assign rd_data = (file_wr.we && file_wr.addr == rd_addr) ?
                     file_wr.data : fm[rd_addr];
    always @(posedge clk_sys) if (file_wr.we) fm[file_wr.addr] <= file_wr.data;

    add_and_bit_ops_executor u_dut (.clk_sys(clk_sys), .rst(rst),
        .instr_valid(instr_valid), .instr(instr), .rd_addr(rd_addr),
        .rd_data(rd_data), .file_wr(file_wr), .acc(acc), .flags(flags),
        .skip_active(skip_active), .instr_done(instr_done));

    task chk(string nm, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task step(logic [13:0] w);
        instr = w;
        instr_valid = 1'b1;
        @(posedge clk_sys);
        #2;
    endtask : step
    function automatic logic [13:0] wl(logic [4:0] o, logic [7:0] k);
        return {o, 1'b0, k};
    endfunction : wl
    function automatic logic [13:0] wt(logic [3:0] o, logic [2:0] b);
        return {o, b, 7'h05};
    endfunction : wt

    task t_arith;
        step(wl(exec_pkg::OPC_ADD_IMM, 8'hff));
        chk("acc", acc, 8'hff);
        step(wl(exec_pkg::OPC_ADD_IMM, 8'h02));
        chk("acc", acc, 8'h01);
        chk("flags", flags, 3'b110);
        chk("done", instr_done, 1'b1);
        step({exec_pkg::OPC_ADD_REG, 8'hff});
        chk("wr", 16'(file_wr), {1'b1, 7'h7f, 8'h10});
        chk("flags", flags, 3'b010);
        step({exec_pkg::OPC_ADD_REG, 8'h7f});
        chk("acc", acc, 8'h11);
        step(wl(exec_pkg::OPC_AND_IMM, 8'h0e));
        chk("acc", acc, 8'h00);
        chk("flags", flags, 3'b001);
        step(wl(exec_pkg::OPC_ADD_IMM, 8'h30));
        step({exec_pkg::OPC_AND_REG, 8'hff});
        chk("wr", 16'(file_wr), {1'b1, 7'h7f, 8'h10});
        chk("acc", acc, 8'h30);
        step({exec_pkg::OPC_AND_REG, 8'h7f});
        chk("acc", acc, 8'h10);
        $display("test arith over");
    endtask : t_arith

    task t_bits;
        logic [7:0] e;
        e = 8'h5a;
        step(wl(exec_pkg::OPC_ADD_IMM, 8'hf0));
        for (int i = 0; i < 16; i++) begin
            step(wt(i < 8 ? exec_pkg::OPC_BIT_SET : exec_pkg::OPC_BIT_CLR,
                    3'(i)));
            e = i < 8 ? e | (8'h01 << i[2:0]) : e & ~(8'h01 << i[2:0]);
            chk("bit", 16'(file_wr), {1'b1, 7'h05, e});
            chk("addr", rd_addr, 7'h05);
            chk("flags", flags, 3'b101);
        end
        $display("test bits over");
    endtask : t_bits

    task t_skip;
        logic sk;
        ea = 8'h00;
        for (int i = 0; i < 4; i++) begin
            sk = i[0] ? i[1] : !i[1];
            step(wt(i[1] ? exec_pkg::OPC_BIT_SET : exec_pkg::OPC_BIT_CLR, 3'h3));
            step(wt(i[0] ? exec_pkg::OPC_SKIP_O : exec_pkg::OPC_SKIP_Z, 3'h3));
            chk("skip", skip_active, sk);
            step(wl(exec_pkg::OPC_ADD_IMM, 8'h01));
            ea = sk ? ea : ea + 8'h01;
            chk("acc", acc, ea);
            chk("skip", skip_active, 1'b0);
        end
        step(14'h0000);
        chk("none", {instr_done, file_wr.we, acc}, {2'b10, ea});
        instr_valid = 1'b0;
        @(posedge clk_sys);
        #2;
        chk("done", instr_done, 1'b0);
        $display("test skip over");
    endtask : t_skip

    task t_reset;
        step(wl(exec_pkg::OPC_ADD_IMM, 8'h7f));
        step(wt(exec_pkg::OPC_SKIP_O, 3'h3));
        chk("skip", skip_active, 1'b1);
        instr_valid = 1'b0;
        rst = 1'b1;
        @(posedge clk_sys);
        #2;
        chk("rst", {acc, flags, skip_active, instr_done, file_wr.we},
            {exec_pkg::ACC_RST, 3'b000, 3'b000});
        rst = 1'b0;
        step(wl(exec_pkg::OPC_ADD_IMM, 8'h01));
        chk("acc", acc, 8'h01);
        $display("test reset over");
    endtask : t_reset

    task close_out;
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    initial begin
        fm[7'h7f] = 8'h0f;
        fm[7'h05] = 8'h5a;
        repeat (6) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        t_arith();
        t_bits();
        t_skip();
        t_reset();
        close_out();
    end
    // whole run is under a hundred cycles
    initial begin
        #20000;
        n_fail++;
        close_out();
    end
endmodule : add_and_bit_ops_executor_test
